// ==== hdl/fcad_flash_ctrl.sv ====
// module: flash control register, keyed launch, lock levels and access decode
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
// ============================================================================
module fcad_flash_ctrl #(
	parameter int PROG_CYCLES = 16,
	parameter int APB_AW      = 12
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [APB_AW-1:0]    paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic [2:0]           lock_bits_in,
	input  wire logic                 ea_pin,
	input  wire fcad_pkg::fcad_loc_e  code_loc,
	input  wire logic                 core_idle,
	input  wire logic                 xdata_rd,
	input  wire logic                 xdata_wr,
	output logic                      xdata_to_external_ram,
	output logic                      xdata_to_eeprom,
	output logic                      xdata_to_latch,
	input  wire logic                 nvm_rd,
	input  wire logic                 nvm_wr,
	input  wire fcad_pkg::fcad_nv_e   nvm_space,
	input  wire logic                 nvm_path,
	output logic                      nvm_allow,
	output logic                      nvm_rww,
	output logic                      prog_launch,
	output fcad_pkg::fcad_sel_e       prog_space,
	output logic                      program_busy,
	output fcad_pkg::fcad_sel_e       code_read_space,
	output logic                      ext_code_read_block,
	output logic                      par_prog_block,
	output logic                      par_verify_block,
	output logic                      rollover_exec_block,
	output logic                      irq
);
	import fcad_pkg::*;

	localparam int CNT_W = $clog2(PROG_CYCLES + 1);

	fcad_dec_if dif ();

	logic               acc;
	logic               hit;
	logic [IDX_W-1:0]   idx;
	logic               wr;
	logic               fc_wr;
	logic [3:0]         key;
	logic [31:0]        rd_mux;
	logic               ev_abort;
	logic               ev_done;
	logic               ev_deny;
	logic [IRQ_W-1:0]   ev_set;
	logic [IRQ_W-1:0]   ev_clr;
	logic [2:0]         lvl;
	logic               ea_eff;
	fcad_state_e        state_reg;
	logic [CNT_W-1:0]   cnt_reg;
	logic               launch_reg;
	fcad_sel_e          space_reg;
	logic               map_reg;
	fcad_sel_e          sel_reg;
	logic               eee_reg;
	logic [IRQ_W-1:0]   status_reg;
	logic [IRQ_W-1:0]   mask_reg;
	logic [2:0]         lock_reg;
	logic               cap_reg;
	logic               ea_lat_reg;
	logic [31:0]        prdata_reg;

	// ==========================================================================
	// apb decode, zero wait states
	assign acc     = psel & penable;
	assign idx     = paddr[ADDR_LSB+IDX_W-1:ADDR_LSB];
	assign hit     = (paddr[APB_AW-1:ADDR_LSB+IDX_W] == '0) && (paddr[ADDR_LSB-1:0] == '0)
		&& ((idx == IDX_FLASH_CONTROL) || (idx == IDX_IRQ_STATUS) || (idx == IDX_IRQ_MASK)
		|| (idx == IDX_ACCESS_CFG) || (idx == IDX_LOCK_STATUS));
	assign wr      = acc & pwrite & hit;
	assign fc_wr   = wr & (idx == IDX_FLASH_CONTROL);
	assign key     = pwdata[KEY_MSB:KEY_LSB];
	assign pready  = 1'b1;
	assign pslverr = acc & ~hit;
	assign prdata  = prdata_reg;

	// read mux, key field reads as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (idx)
			IDX_FLASH_CONTROL: rd_mux = {24'h00_0000, 4'h0, map_reg, sel_reg, program_busy};
			IDX_IRQ_STATUS:    rd_mux = {29'h0000_0000, status_reg};
			IDX_IRQ_MASK:      rd_mux = {29'h0000_0000, mask_reg};
			IDX_ACCESS_CFG:    rd_mux = {31'h0000_0000, eee_reg};
			IDX_LOCK_STATUS:   rd_mux = {25'h000_0000, ea_lat_reg, lvl, lock_reg};
			default:           rd_mux = 32'h0000_0000;
		endcase
	end

	// read data captured in the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_reg <= hit ? rd_mux : 32'h0000_0000;
		end
	end

	// ==========================================================================
	// software fields of flash_control and access config
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			map_reg <= MAP_RST;
			sel_reg <= FCAD_SEL_USER;
			eee_reg <= 1'b0;
		end else begin
			if (fc_wr) begin
				map_reg <= pwdata[MAP_BIT];
				sel_reg <= fcad_sel_e'(pwdata[SEL_MSB:SEL_LSB]);
			end
			if (wr && idx == IDX_ACCESS_CFG) begin
				eee_reg <= pwdata[EEE_BIT];
			end
		end
	end
	assign code_read_space = sel_reg;

	// ==========================================================================
	// launch sequencer, any access between the keys other than a repeated first-key write breaks the sequence
	assign ev_abort = (state_reg == FCAD_ST_ARMED)
		&& ((acc && !(fc_wr && (key == KEY_FIRST || key == KEY_SECOND)))
		|| xdata_rd || xdata_wr || nvm_rd || nvm_wr);
	assign ev_done  = (state_reg == FCAD_ST_BUSY) && (cnt_reg == '0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg  <= FCAD_ST_IDLE;
			cnt_reg    <= '0;
			launch_reg <= 1'b0;
			space_reg  <= FCAD_SEL_USER;
		end else begin
			launch_reg <= 1'b0;
			case (state_reg)
				FCAD_ST_IDLE: begin
					if (fc_wr && key == KEY_FIRST) begin
						state_reg <= FCAD_ST_ARMED;
					end
				end
				FCAD_ST_ARMED: begin
					if (fc_wr && key == KEY_SECOND && dif.launch_ok) begin
						state_reg  <= FCAD_ST_BUSY;
						cnt_reg    <= CNT_W'(PROG_CYCLES - 1);
						launch_reg <= 1'b1;
						space_reg  <= fcad_sel_e'(pwdata[SEL_MSB:SEL_LSB]);
					end else if (fc_wr && key == KEY_FIRST) begin
						state_reg <= FCAD_ST_ARMED;
					end else if (fc_wr || ev_abort) begin
						state_reg <= FCAD_ST_IDLE;
					end
				end
				FCAD_ST_BUSY: begin
					if (cnt_reg == '0) begin
						state_reg <= FCAD_ST_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				default: state_reg <= FCAD_ST_IDLE;
			endcase
		end
	end
	// a second key seen in idle falls through the idle branch untouched
	assign program_busy = (state_reg == FCAD_ST_BUSY);
	assign prog_launch  = launch_reg;
	assign prog_space   = space_reg;

	// ==========================================================================
	// lock bits and access pin caught once after reset release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_reg   <= LOCK_DEFAULT;
			cap_reg    <= 1'b0;
			ea_lat_reg <= 1'b0;
		end else if (!cap_reg) begin
			lock_reg   <= lock_bits_in;
			ea_lat_reg <= ea_pin;
			cap_reg    <= 1'b1;
		end
	end

	// security level and its blocks, higher bits take precedence
	assign lvl = lock_reg[2] ? LVL4 : (lock_reg[1] ? LVL3 : (lock_reg[0] ? LVL2 : LVL1));
	assign ea_eff              = (lvl != LVL1) ? ea_lat_reg : ea_pin;
	assign ext_code_read_block = (lvl != LVL1);
	assign par_prog_block      = (lvl != LVL1);
	assign par_verify_block    = (lvl == LVL3) || (lvl == LVL4);
	assign rollover_exec_block = (lvl == LVL4);

	// ==========================================================================
	// access decoder
	assign dif.loc   = code_loc;
	assign dif.space = nvm_space;
	assign dif.sel   = fcad_sel_e'(pwdata[SEL_MSB:SEL_LSB]);
	assign dif.idle  = core_idle;
	assign dif.eee   = eee_reg;
	assign dif.map   = map_reg;
	assign dif.ea    = ea_eff;
	assign dif.xd_rd = xdata_rd;
	assign dif.xd_wr = xdata_wr | nvm_wr;
	assign dif.path  = nvm_path;

	fcad_access_decode u_dec (
		.dif (dif.dec)
	);

	assign xdata_to_external_ram   = dif.to_external_ram & (xdata_rd | xdata_wr);
	assign xdata_to_eeprom = dif.to_eeprom & (xdata_rd | xdata_wr);
	assign xdata_to_latch  = dif.to_latch & xdata_wr;
	assign nvm_allow       = dif.nv_ok & (nvm_rd | nvm_wr);
	assign nvm_rww         = dif.nv_rww & nvm_wr;
	assign ev_deny         = (nvm_rd | nvm_wr) & ~nvm_allow;

	// ==========================================================================
	// interrupts: sticky, read clears only what was reported, set wins
	assign ev_set = {ev_deny, ev_abort, ev_done};
	assign ev_clr = (acc && !pwrite && hit && idx == IDX_IRQ_STATUS)
		? prdata_reg[IRQ_W-1:0] : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= '0;
			mask_reg   <= '0;
		end else begin
			status_reg <= (status_reg & ~ev_clr) | ev_set;
			if (wr && idx == IDX_IRQ_MASK) begin
				mask_reg <= pwdata[IRQ_W-1:0];
			end
		end
	end
	assign irq = |(status_reg & mask_reg);

	// ==========================================================================
	// assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_busy_run;
		program_busy ##PROG_CYCLES !program_busy;
	endsequence

	sequence s_lone_key2;
		(state_reg == FCAD_ST_IDLE) && fc_wr && (key == KEY_SECOND);
	endsequence

	a_launch_armed: assert property (prog_launch |-> $past(state_reg) == FCAD_ST_ARMED)
		else $error("launch without armed sequencer");
	a_busy_length: assert property (prog_launch |-> s_busy_run)
		else $error("busy length wrong");
	a_busy_sw_ro: assert property ((state_reg == FCAD_ST_IDLE && fc_wr && pwdata[BUSY_BIT])
		|=> !program_busy)
		else $error("software set busy");
	a_lone_key2: assert property (s_lone_key2 |=> (state_reg == FCAD_ST_IDLE) && !prog_launch)
		else $error("second key alone acted");
	a_rsvd_noop: assert property ((state_reg == FCAD_ST_ARMED && fc_wr && key == KEY_SECOND
		&& pwdata[SEL_MSB:SEL_LSB] == FCAD_SEL_RSVD) |=> !prog_launch)
		else $error("reserved space launched");
	a_rd_route: assert property (xdata_rd |-> !xdata_to_latch
		&& (xdata_to_eeprom == (eee_reg && !map_reg)))
		else $error("data read routed wrong");
	a_wr_latch: assert property ((xdata_wr && map_reg && ea_eff)
		|-> xdata_to_latch && !xdata_to_eeprom && !xdata_to_external_ram)
		else $error("data write missed latch");
	a_boot_extra_row: assert property ((code_loc == FCAD_LOC_BOOT && nvm_rd
		&& nvm_space == FCAD_NV_EXTRA_ROW) |-> !nvm_allow)
		else $error("boot read of extra row allowed");
	a_user_idle: assert property ((code_loc == FCAD_LOC_USER && nvm_wr
		&& nvm_space == FCAD_NV_USER && !core_idle) |-> !nvm_allow)
		else $error("user flash write while busy core");
	a_ext_eeprom: assert property ((code_loc == FCAD_LOC_EXT && nvm_allow)
		|-> nvm_space == FCAD_NV_EEPROM)
		else $error("external code reached flash");
	a_flash_path: assert property ((nvm_wr && nvm_space != FCAD_NV_EEPROM && !nvm_path)
		|-> !nvm_allow)
		else $error("direct flash write allowed");
	a_lock_fixed: assert property ((cap_reg && $past(cap_reg)) |-> $stable(lock_reg))
		else $error("lock bits changed");
	a_ea_latched: assert property ((cap_reg && lvl != LVL1) |-> ea_eff == ea_lat_reg)
		else $error("access pin not latched");
	a_verify_nest: assert property (par_verify_block |-> par_prog_block)
		else $error("verify block without level two");
	a_roll_nest: assert property (rollover_exec_block |-> par_verify_block)
		else $error("roll-over block without level three");
	a_level1_open: assert property ((cap_reg && lock_reg == 3'h0)
		|-> !ext_code_read_block && !par_prog_block)
		else $error("level one protected");
endmodule : fcad_flash_ctrl

// ==== hdl/fcad_pkg.sv ====
// package: register map, field layout and constants of the flash control block
package fcad_pkg;
	// ==========================================================================
	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_FLASH_CONTROL = 8'hD1;
	localparam logic [7:0] IDX_IRQ_STATUS    = 8'hE0;
	localparam logic [7:0] IDX_IRQ_MASK      = 8'hE1;
	localparam logic [7:0] IDX_ACCESS_CFG    = 8'hE2;
	localparam logic [7:0] IDX_LOCK_STATUS   = 8'hE3;
	localparam int         ADDR_LSB          = 2;
	localparam int         IDX_W             = 8;
	// ==========================================================================
	// flash_control fields
	localparam int         KEY_MSB           = 7;
	localparam int         KEY_LSB           = 4;
	localparam int         MAP_BIT           = 3;
	localparam int         SEL_MSB           = 2;
	localparam int         SEL_LSB           = 1;
	localparam int         BUSY_BIT          = 0;
	localparam logic [3:0] KEY_FIRST         = 4'h5;
	localparam logic [3:0] KEY_SECOND        = 4'hA;
	localparam logic       MAP_RST           = 1'h0;
	localparam int         EEE_BIT           = 0;
	// ==========================================================================
	// interrupt bits
	localparam int         IRQ_DONE          = 0;
	localparam int         IRQ_ABORT         = 1;
	localparam int         IRQ_DENY          = 2;
	localparam int         IRQ_W             = 3;
	// ==========================================================================
	// lock bits, one means programmed; default is level 4
	localparam logic [2:0] LOCK_DEFAULT      = 3'h4;
	localparam logic [2:0] LVL1              = 3'h1;
	localparam logic [2:0] LVL2              = 3'h2;
	localparam logic [2:0] LVL3              = 3'h3;
	localparam logic [2:0] LVL4              = 3'h4;
	// ==========================================================================
	// types
	typedef enum logic [1:0] {FCAD_SEL_USER = 2'h0, FCAD_SEL_EXTRA_ROW = 2'h1,
		FCAD_SEL_HWBYTE = 2'h2, FCAD_SEL_RSVD = 2'h3} fcad_sel_e;
	typedef enum logic [1:0] {FCAD_LOC_BOOT = 2'h0, FCAD_LOC_USER = 2'h1,
		FCAD_LOC_EXT = 2'h2} fcad_loc_e;
	typedef enum logic [2:0] {FCAD_NV_BOOT = 3'h0, FCAD_NV_USER = 3'h1,
		FCAD_NV_EEPROM = 3'h2, FCAD_NV_HWBYTE = 3'h3, FCAD_NV_EXTRA_ROW = 3'h4} fcad_nv_e;
	typedef enum logic [1:0] {FCAD_ST_IDLE = 2'h0, FCAD_ST_ARMED = 2'h1,
		FCAD_ST_BUSY = 2'h3} fcad_state_e;
endpackage : fcad_pkg

// ==== hdl/fcad_dec_if.sv ====
// interface: signals between the control top and the access decoder
`timescale 1ns/1ps
interface fcad_dec_if;
	import fcad_pkg::*;
	fcad_loc_e loc;
	fcad_nv_e  space;
	fcad_sel_e sel;
	logic      idle;
	logic      eee;
	logic      map;
	logic      ea;
	logic      xd_rd;
	logic      xd_wr;
	logic      path;
	logic      to_external_ram;
	logic      to_eeprom;
	logic      to_latch;
	logic      nv_ok;
	logic      nv_rww;
	logic      launch_ok;
	modport dec (input loc, space, sel, idle, eee, map, ea, xd_rd, xd_wr, path,
		output to_external_ram, to_eeprom, to_latch, nv_ok, nv_rww, launch_ok);
	modport ctl (output loc, space, sel, idle, eee, map, ea, xd_rd, xd_wr, path,
		input to_external_ram, to_eeprom, to_latch, nv_ok, nv_rww, launch_ok);
endinterface : fcad_dec_if

// ==== hdl/fcad_access_decode.sv ====
// module: data-move routing and nonvolatile access permission decode
`timescale 1ns/1ps
module fcad_access_decode (
	fcad_dec_if.dec dif
);
	import fcad_pkg::*;

	logic rd_eep;
	logic wr_eep;
	logic wr_lat;
	logic [1:0] perm;
	logic [1:0] lperm;
	fcad_nv_e   lspace;

	// ==========================================================================
	// permission lookup: bit1 allowed, bit0 read while write
	function automatic logic [1:0] fcad_perm(input fcad_loc_e loc, input fcad_nv_e sp,
		input logic wr, input logic idle);
		logic ok;
		logic rww;
		ok  = 1'b0;
		rww = 1'b0;
		case (loc)
			FCAD_LOC_BOOT: begin
				ok  = wr ? (sp != FCAD_NV_BOOT) : (sp != FCAD_NV_EXTRA_ROW);
				rww = wr;
			end
			FCAD_LOC_USER: begin
				if (wr) begin
					ok = (sp == FCAD_NV_EEPROM) || (sp == FCAD_NV_EXTRA_ROW)
						|| ((sp == FCAD_NV_USER) && idle);
				end else begin
					ok = (sp == FCAD_NV_USER) || (sp == FCAD_NV_EEPROM)
						|| (sp == FCAD_NV_HWBYTE);
				end
				rww = wr && (sp == FCAD_NV_EEPROM);
			end
			FCAD_LOC_EXT: begin
				ok  = (sp == FCAD_NV_EEPROM);
				rww = wr;
			end
			default: begin
				ok  = 1'b0;
				rww = 1'b0;
			end
		endcase
		return {ok, rww & ok};
	endfunction : fcad_perm

	// ==========================================================================
	// data-move routing
	assign rd_eep        = dif.xd_rd & dif.eee & ~dif.map;
	assign wr_lat        = dif.xd_wr & dif.map & dif.ea;
	assign wr_eep        = dif.xd_wr & dif.eee & ~dif.map;
	assign dif.to_latch  = wr_lat;
	assign dif.to_eeprom = rd_eep | wr_eep;
	assign dif.to_external_ram   = (dif.xd_rd & ~rd_eep) | (dif.xd_wr & ~wr_lat & ~wr_eep);

	// flash spaces go by code read or column latch, eeprom by data move
	assign perm       = fcad_perm(dif.loc, dif.space, dif.xd_wr, dif.idle);
	assign dif.nv_ok  = perm[1] & (dif.path == (dif.space != FCAD_NV_EEPROM));
	assign dif.nv_rww = perm[0] & dif.nv_ok;

	// launch target must be writable from the running code
	always_comb begin
		case (dif.sel)
			FCAD_SEL_USER:   lspace = FCAD_NV_USER;
			FCAD_SEL_EXTRA_ROW:   lspace = FCAD_NV_EXTRA_ROW;
			FCAD_SEL_HWBYTE: lspace = FCAD_NV_HWBYTE;
			default:         lspace = FCAD_NV_BOOT;
		endcase
	end
	assign lperm         = fcad_perm(dif.loc, lspace, 1'b1, dif.idle);
	assign dif.launch_ok = lperm[1] & (dif.sel != FCAD_SEL_RSVD);
endmodule : fcad_access_decode

// ==== verification/fcad_core_model.sv ====
// file: behavioural model of the cpu core issuing data-move and code accesses
`timescale 1ns/1ps
module fcad_core_model (
	input  wire logic           pclk,
	output fcad_pkg::fcad_loc_e code_loc,
	output logic                core_idle,
	output logic                xdata_rd,
	output logic                xdata_wr,
	output logic                nvm_rd,
	output logic                nvm_wr,
	output fcad_pkg::fcad_nv_e  nvm_space,
	output logic                nvm_path
);
	import fcad_pkg::*;
	// ========================================================================
	// power-up: running from boot flash, no access pending
	initial begin
		code_loc = FCAD_LOC_BOOT;
		nvm_space = FCAD_NV_BOOT;
		{core_idle, xdata_rd, xdata_wr, nvm_rd, nvm_wr, nvm_path} = 6'h00;
	end
	// ========================================================================
	// one access pattern per call, changed just after a rising edge
	// never slips an access between the two key writes unless told to
	task automatic issue(input logic [10:0] v);
		@(posedge pclk);
		code_loc <= fcad_loc_e'(v[10:9]);
		nvm_space <= fcad_nv_e'(v[3:1]);
		{core_idle, xdata_rd, xdata_wr, nvm_rd, nvm_wr} <= v[8:4];
		nvm_path <= v[0];
	endtask : issue
endmodule : fcad_core_model

// ==== verification/flash_control_access_decode_tb.sv ====
// file: self-checking bench of the flash control and access decode block
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
	$display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); end end
module flash_control_access_decode_tb;
	import fcad_pkg::*;
	localparam int PROG = 4;
	typedef struct packed {logic [2:0] env; logic [10:0] core; logic [4:0] mask;
		logic [4:0] expv;} fcad_row_s;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ea_pin;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic [2:0]  lock_bits;
	logic        core_idle, xdata_rd, xdata_wr, nvm_rd, nvm_wr, nvm_path, er;
	logic        xdata_to_external_ram, xdata_to_eeprom, xdata_to_latch, nvm_allow, nvm_rww;
	logic        prog_launch, program_busy, irq;
	logic        ext_blk, pprog_blk, pver_blk, roll_blk;
	logic [3:0]  blocks;
	logic [4:0]  route;
	fcad_loc_e   code_loc;
	fcad_nv_e    nvm_space;
	fcad_sel_e   prog_space, code_read_space;
	int          err_total, n_compared, n;
	logic [9:0]  lvl_rows [4] = '{10'h24F, 10'h0AC, 10'h1BE, 10'h010};
	fcad_row_s   rows [32] = '{
		'{3'h1, 11'h180, 5'h1C, 5'h10}, '{3'h3, 11'h180, 5'h1C, 5'h10},
		'{3'h5, 11'h180, 5'h1C, 5'h08}, '{3'h7, 11'h180, 5'h1C, 5'h10},
		'{3'h1, 11'h140, 5'h1C, 5'h10}, '{3'h3, 11'h140, 5'h1C, 5'h04},
		'{3'h2, 11'h140, 5'h1C, 5'h10}, '{3'h5, 11'h140, 5'h1C, 5'h08},
		'{3'h7, 11'h140, 5'h1C, 5'h04}, '{3'h6, 11'h140, 5'h1C, 5'h10},
		'{3'h1, 11'h121, 5'h02, 5'h02}, '{3'h1, 11'h129, 5'h02, 5'h00},
		'{3'h1, 11'h124, 5'h02, 5'h02}, '{3'h1, 11'h127, 5'h02, 5'h02},
		'{3'h1, 11'h122, 5'h02, 5'h00}, '{3'h1, 11'h111, 5'h02, 5'h00},
		'{3'h1, 11'h117, 5'h03, 5'h03}, '{3'h1, 11'h119, 5'h03, 5'h03},
		'{3'h1, 11'h112, 5'h02, 5'h00}, '{3'h1, 11'h114, 5'h03, 5'h03},
		'{3'h1, 11'h321, 5'h02, 5'h00}, '{3'h1, 11'h327, 5'h02, 5'h02},
		'{3'h1, 11'h329, 5'h02, 5'h00}, '{3'h1, 11'h313, 5'h03, 5'h02},
		'{3'h1, 11'h213, 5'h02, 5'h00}, '{3'h1, 11'h317, 5'h02, 5'h00},
		'{3'h1, 11'h319, 5'h03, 5'h02}, '{3'h1, 11'h314, 5'h03, 5'h03},
		'{3'h1, 11'h524, 5'h02, 5'h02}, '{3'h1, 11'h523, 5'h02, 5'h00},
		'{3'h1, 11'h514, 5'h03, 5'h03}, '{3'h1, 11'h513, 5'h02, 5'h00}};
	assign blocks = {ext_blk, pprog_blk, pver_blk, roll_blk};
	assign route  = {xdata_to_external_ram, xdata_to_eeprom, xdata_to_latch, nvm_allow, nvm_rww};
	// ========================================================================
	// design and core model
	fcad_flash_ctrl #(.PROG_CYCLES(PROG), .APB_AW(12)) fcad_flash_ctrl_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .lock_bits_in(lock_bits), .ea_pin(ea_pin),
		.code_loc(code_loc), .core_idle(core_idle), .xdata_rd(xdata_rd),
		.xdata_wr(xdata_wr), .xdata_to_external_ram(xdata_to_external_ram),
		.xdata_to_eeprom(xdata_to_eeprom), .xdata_to_latch(xdata_to_latch),
		.nvm_rd(nvm_rd), .nvm_wr(nvm_wr), .nvm_space(nvm_space), .nvm_path(nvm_path),
		.nvm_allow(nvm_allow), .nvm_rww(nvm_rww), .prog_launch(prog_launch),
		.prog_space(prog_space), .program_busy(program_busy),
		.code_read_space(code_read_space), .ext_code_read_block(ext_blk),
		.par_prog_block(pprog_blk), .par_verify_block(pver_blk),
		.rollover_exec_block(roll_blk), .irq(irq));
	fcad_core_model fcad_core_model_inst (.pclk(pclk), .code_loc(code_loc),
		.core_idle(core_idle), .xdata_rd(xdata_rd), .xdata_wr(xdata_wr),
		.nvm_rd(nvm_rd), .nvm_wr(nvm_wr), .nvm_space(nvm_space), .nvm_path(nvm_path));
	// ========================================================================
	// clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// ========================================================================
	// verdict and end of run
	task automatic tally_and_finish;
		$display("mismatches %0d, compares %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish
	// apb transfer, request held until pready is seen high; no release
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
			tally_and_finish();
		end
		d = prdata;
		er = pslverr;
	endtask : apb
	// release the bus and let one edge pass
	task automatic rel;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : rel
	task automatic wreg(input logic [7:0] idx, input logic [31:0] wd);
		apb(1'b1, idx, wd);
		rel();
	endtask : wreg
	task automatic rreg(input logic [7:0] idx);
		apb(1'b0, idx, 32'h0);
		rel();
	endtask : rreg
	// reset with given lock bits; lock register reads level four meanwhile
	task automatic do_reset(input logic [2:0] lb);
		presetn <= 1'b0;
		lock_bits <= lb;
		repeat (2) @(posedge pclk);
		`CHK({blocks, program_busy, prog_launch}, 6'h3C);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask : do_reset
	// ========================================================================
	// main sequence
	initial begin
		{presetn, psel, penable} = '0;
		{err_total, n_compared} = '0;
		ea_pin = 1'b1;
		// lock levels; level two and three only set on verified parts
		foreach (lvl_rows[i]) begin
			do_reset(lvl_rows[i][9:7]);
			`CHK(blocks, lvl_rows[i][3:0]);
			wreg(IDX_LOCK_STATUS, 32'h0);
			rreg(IDX_LOCK_STATUS);
			`CHK(d[5:0], {lvl_rows[i][6:4], lvl_rows[i][9:7]});
		end
		// level two keeps the access pin as latched at reset
		do_reset(3'h1);
		ea_pin <= 1'b0;
		wreg(IDX_FLASH_CONTROL, 32'h08);
		fcad_core_model_inst.issue(11'h140);
		@(posedge pclk);
		`CHK(xdata_to_latch, 1'b1);
		fcad_core_model_inst.issue(11'h000);
		do_reset(3'h0);
		// busy bit ignores software, key field reads zero
		wreg(IDX_FLASH_CONTROL, 32'h0D);
		rreg(IDX_FLASH_CONTROL);
		`CHK(d, 32'h0C);
		`CHK(code_read_space, FCAD_SEL_HWBYTE);
		apb(1'b0, 8'h10, 32'h0);
		rel();
		`CHK({er, d}, {1'b1, 32'h0});
		// routing and permission table
		foreach (rows[i]) begin
			wreg(IDX_ACCESS_CFG, {31'h0, rows[i].env[2]});
			wreg(IDX_FLASH_CONTROL, {28'h0, rows[i].env[1], 3'h0});
			ea_pin <= rows[i].env[0];
			fcad_core_model_inst.issue(rows[i].core);
			@(posedge pclk);
			`CHK(route & rows[i].mask, rows[i].expv);
		end
		fcad_core_model_inst.issue(11'h000);
		wreg(IDX_IRQ_MASK, 32'h1);
		// denied table rows left the deny bit; it is masked off irq and read clears it
		rreg(IDX_IRQ_STATUS);
		`CHK({d[2:0], irq}, 4'h8);
		// keyed launch of the user, extra row and hardware byte spaces, keys back to back
		for (int s = 0; s < 3; s++) begin
			apb(1'b1, IDX_FLASH_CONTROL, 32'h50 | (s << 1));
			apb(1'b1, IDX_FLASH_CONTROL, 32'hA0 | (s << 1));
			psel <= 1'b0;
			penable <= 1'b0;
			@(negedge pclk);
			`CHK({prog_launch, program_busy, prog_space}, {2'b11, s[1:0]});
			n = 0;
			while (program_busy === 1'b1 && n < 50) begin
				@(negedge pclk);
				n++;
			end
			`CHK(n, PROG);
			`CHK(irq, 1'b1);
			@(posedge pclk);
			rreg(IDX_IRQ_STATUS);
			`CHK({d[2:0], irq}, 4'h2);
		end
		// reserved space and a lone second key launch nothing
		apb(1'b1, IDX_FLASH_CONTROL, 32'h56);
		apb(1'b1, IDX_FLASH_CONTROL, 32'hA6);
		rel();
		`CHK({prog_launch, program_busy}, 2'b00);
		wreg(IDX_FLASH_CONTROL, 32'hA0);
		`CHK({prog_launch, program_busy}, 2'b00);
		rreg(IDX_IRQ_STATUS);
		`CHK(d[2:0], 3'h0);
		// core access between the keys aborts; abort bit masked off irq
		wreg(IDX_FLASH_CONTROL, 32'h50);
		fcad_core_model_inst.issue(11'h180);
		fcad_core_model_inst.issue(11'h000);
		wreg(IDX_FLASH_CONTROL, 32'hA0);
		`CHK({prog_launch, program_busy, irq}, 3'h0);
		rreg(IDX_IRQ_STATUS);
		`CHK(d[2:0], 3'h2);
		tally_and_finish();
	end
endmodule : flash_control_access_decode_tb
